/* File: common/stop_seq_pkg.sv */
// constants, types and register map for the stop-mode power sequencer
// assumes a single 40 MHz bus clock and an apb master for software access
// ****************************************************************
// Function
// - stop instruction enters stop only if stop enable set, else illegal-opcode reset
// - no debug: stop3 if power-down bit clear, stop2 both set, stop1 full only
// - monitor and its stop enable both set at entry keep regulator fully active in stop3
// - debug enabled at entry keeps debug clocks running during stop
// - debug enabled at entry keeps regulator out of standby, full regulation
// - in stop, status memory commands do no access and return stop error
// - background command with debug enabled wakes stop into background mode
// - entering stop2 latches pin outputs and output enables (pull-ups still follow software) so pins hold their state
// - in stop1/stop2 wake pin is active-low wake input, pull-up not forced
// - enabled periodic wake timer also wakes from stop1 or stop2
// - deep-stop wake restarts like power-on: registers reset, reset vector fetched
// - after deep-stop wake low-voltage reset is on at low trip point
// - stop2 wake sets partial flag; flag and pin latches hold until ack written 1
// - on ack gpio pins take current port register values
// - on unlatch, pins of disabled peripherals follow port control registers
// - entering stop1 puts every pin in high impedance
// - stop1 wake sets full flag, held until ack written 1
// - peripheral clocks halt in every stop mode, even with debug clocks on
// - stop2 keeps only ram and regulator in standby; rest powered off
// - stop3 converter runs only with its async clock and monitor enabled
// - stop3 clock source runs only with reference and stop enables set
// ****************************************************************
package stop_seq_pkg;

  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned WAKE_PIN  = 5;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;

  localparam int unsigned B_STOP_EN   = 0;
  localparam int unsigned B_PDC       = 1;
  localparam int unsigned B_PARTIAL_POWERDOWN_CONTROL      = 2;
  localparam int unsigned B_VM_EN     = 3;
  localparam int unsigned B_VM_STOP   = 4;
  localparam int unsigned B_REF_CLK   = 5;
  localparam int unsigned B_REF_STOP  = 6;
  localparam int unsigned B_ADC_ASYNC = 7;
  localparam int unsigned B_RTI_EN    = 8;
  localparam int unsigned CTRL_W      = 9;

  localparam int unsigned B_PARTIAL_POWERDOWN_FLAG      = 0;
  localparam int unsigned B_PDF       = 1;
  localparam int unsigned B_STATE_LO  = 2;
  localparam int unsigned B_ACK       = 8;

  // monitor enabled after power-on, everything else off
  localparam logic [8:0] CTRL_RST = 9'h008;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned RESTART_NS     = 1000;
  localparam int unsigned RESTART_CYCLES =
    (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_STOP3   = 3'b001,
    ST_STOP2   = 3'b011,
    ST_STOP1   = 3'b010,
    ST_RESTART = 3'b110
  } pwr_state_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic cpu;
    logic ram;
    logic flash;
    logic port_regs;
    logic periph_clk;
    logic debug_clk;
    logic reg_full;
    logic reg_standby;
    logic adc_run;
    logic ics_run;
  } pwr_ctl_t;

endpackage

/* File: hdl/stop_mode_power_sequencer.sv */
// stop-mode power sequencer: stop entry, wake, restart and pin latching
// assumes the sequencer clock keeps running in every stop mode (always-on)
// and that cpu, debug and wake-timer strobes are synchronous to i_mclk
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
module stop_mode_power_sequencer #(
  parameter int unsigned PINS = stop_seq_pkg::PIN_COUNT
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_srst,
  input  wire stop_seq_pkg::apb_req_t i_apb,
  output stop_seq_pkg::apb_rsp_t      o_apb,
  input  wire logic                   i_stop_exec,
  input  wire logic                   i_debug_mode_enable,
  input  wire logic                   i_bkgd_cmd,
  input  wire logic                   i_mem_status_cmd,
  input  wire logic                   i_irq_wake,
  input  wire logic                   i_rti_wake,
  input  wire logic                   i_wake_pin_n,
  input  wire logic                   i_vdd_below_low_trip,
  input  wire logic [PINS-1:0]        i_port_data,
  input  wire logic [PINS-1:0]        i_port_dir,
  input  wire logic [PINS-1:0]        i_port_pullup_enables,
  input  wire logic [PINS-1:0]        i_periph_en,
  input  wire logic [PINS-1:0]        i_periph_out,
  input  wire logic [PINS-1:0]        i_periph_oe,
  output logic [PINS-1:0]             o_pin_o,
  output logic [PINS-1:0]             o_pin_oe,
  output logic [PINS-1:0]             o_pin_pullup,
  output logic                        o_illegal_op_reset,
  output logic                        o_sys_reset,
  output logic                        o_lvr_enable,
  output logic                        o_lvr_low_trip,
  output logic                        o_enter_background,
  output logic                        o_mem_status_err,
  output logic                        o_debug_cmds_all,
  output stop_seq_pkg::pwr_ctl_t      o_pwr
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    stop_seq_pkg::pwr_state_t st;
    logic [stop_seq_pkg::CTRL_W-1:0] ctrl;
    logic       partial_powerdown_flag;
    logic       full_powerdown_flag;
    logic       dbg_entry;
    logic       vm_keep;
    logic [1:0] wake_sync;
    logic [1:0] vdd_sync;
    logic [7:0] cnt;
    logic [PINS-1:0] pin_o;
    logic [PINS-1:0] pin_oe;
    logic [PINS-1:0] pull;
    logic       ill;
    logic       bgnd;
    logic       mserr;
    logic [31:0] rdata;
    logic       slverr;
  } seq_state_t;

  seq_state_t state_ff;
  seq_state_t nxt_state;

  localparam seq_state_t STATE_RST = '{
    st:        stop_seq_pkg::ST_RUN,
    ctrl:      stop_seq_pkg::CTRL_RST,
    partial_powerdown_flag:      1'b0,
    full_powerdown_flag:       1'b0,
    dbg_entry: 1'b0,
    vm_keep:   1'b0,
    wake_sync: 2'b11,
    vdd_sync:  2'b00,
    cnt:       8'h00,
    pin_o:     '0,
    pin_oe:    '0,
    pull:      '0,
    ill:       1'b0,
    bgnd:      1'b0,
    mserr:     1'b0,
    rdata:     32'h0000_0000,
    slverr:    1'b0
  };

  localparam logic [7:0] RESTART_LAST =
    8'(stop_seq_pkg::RESTART_CYCLES - 1);

  // ****************************************************************
  // next state
  // ****************************************************************
  logic            setup;
  logic            wr_access;
  logic            deep;
  logic            stopped;
  logic            pin_wake;
  logic            deep_wake;
  logic            ack;
  logic            hold_pins;
  logic [PINS-1:0] live_o;
  logic [PINS-1:0] live_oe;
  logic [31:0]     rd;

  always_comb begin
    nxt_state = state_ff;
    setup     = i_apb.psel && !i_apb.penable;
    wr_access = i_apb.psel && i_apb.penable && i_apb.pwrite;
    deep      = (state_ff.st == stop_seq_pkg::ST_STOP1) ||
                (state_ff.st == stop_seq_pkg::ST_STOP2);
    stopped   = deep || (state_ff.st == stop_seq_pkg::ST_STOP3);
    // the pin path is synchronised only for this always-on sequencer;
    // the pad wake itself is an async level and needs no system clock
    pin_wake  = !state_ff.wake_sync[1];
    deep_wake = deep && (pin_wake ||
                (state_ff.ctrl[stop_seq_pkg::B_RTI_EN] && i_rti_wake));
    ack       = wr_access && (i_apb.paddr == stop_seq_pkg::OFS_CTRL_TWO) &&
                i_apb.pwdata[stop_seq_pkg::B_ACK];

    nxt_state.wake_sync = {state_ff.wake_sync[0], i_wake_pin_n};
    nxt_state.vdd_sync  = {state_ff.vdd_sync[0], i_vdd_below_low_trip};
    nxt_state.ill       = 1'b0;
    nxt_state.bgnd      = 1'b0;
    nxt_state.mserr     = stopped && i_mem_status_cmd;

    // software control register writes
    if (wr_access && (i_apb.paddr == stop_seq_pkg::OFS_CTRL_ONE)) begin
      nxt_state.ctrl = i_apb.pwdata[stop_seq_pkg::CTRL_W-1:0];
    end

    case (state_ff.st)
      stop_seq_pkg::ST_RUN: begin
        if (i_stop_exec) begin
          if (!state_ff.ctrl[stop_seq_pkg::B_STOP_EN]) begin
            nxt_state.ill = 1'b1;
          end else begin
            nxt_state.dbg_entry = i_debug_mode_enable;
            nxt_state.vm_keep   = state_ff.ctrl[stop_seq_pkg::B_VM_EN] &&
                                  state_ff.ctrl[stop_seq_pkg::B_VM_STOP];
            if (i_debug_mode_enable ||
                !state_ff.ctrl[stop_seq_pkg::B_PDC]) begin
              nxt_state.st = stop_seq_pkg::ST_STOP3;
            end else if (state_ff.ctrl[stop_seq_pkg::B_PARTIAL_POWERDOWN_CONTROL]) begin
              nxt_state.st = stop_seq_pkg::ST_STOP2;
            end else begin
              nxt_state.st = stop_seq_pkg::ST_STOP1;
            end
          end
        end
      end
      stop_seq_pkg::ST_STOP3: begin
        if (state_ff.dbg_entry && i_bkgd_cmd) begin
          nxt_state.bgnd = 1'b1;
          nxt_state.st   = stop_seq_pkg::ST_RUN;
        end else if (i_irq_wake ||
                     (state_ff.ctrl[stop_seq_pkg::B_RTI_EN] && i_rti_wake)) begin
          nxt_state.st = stop_seq_pkg::ST_RUN;
        end
      end
      stop_seq_pkg::ST_STOP2: begin
        if (deep_wake) begin
          nxt_state.partial_powerdown_flag = 1'b1;
          nxt_state.st   = stop_seq_pkg::ST_RESTART;
        end
      end
      stop_seq_pkg::ST_STOP1: begin
        if (deep_wake) begin
          nxt_state.full_powerdown_flag = 1'b1;
          nxt_state.st  = stop_seq_pkg::ST_RESTART;
        end
      end
      stop_seq_pkg::ST_RESTART: begin
        // power-on style restart: control back to reset values
        nxt_state.ctrl      = stop_seq_pkg::CTRL_RST;
        nxt_state.dbg_entry = 1'b0;
        nxt_state.vm_keep   = 1'b0;
        if (state_ff.cnt != RESTART_LAST) begin
          nxt_state.cnt = state_ff.cnt + 8'h01;
        end else if (!state_ff.vdd_sync[1]) begin
          nxt_state.cnt = 8'h00;
          nxt_state.st  = stop_seq_pkg::ST_RUN;
        end
      end
      default: begin
        nxt_state.st = stop_seq_pkg::ST_RUN;
      end
    endcase

    // set wins over a clear in the same cycle
    if (ack && !deep_wake) begin
      nxt_state.partial_powerdown_flag = 1'b0;
      nxt_state.full_powerdown_flag  = 1'b0;
    end

    // ****************************************************************
    // pin control
    // ****************************************************************
    // disabled peripherals fall back to the port registers
    live_o  = (i_periph_en & i_periph_out) | (~i_periph_en & i_port_data);
    live_oe = (i_periph_en & i_periph_oe)  | (~i_periph_en & i_port_dir);
    hold_pins = (state_ff.st == stop_seq_pkg::ST_STOP2) ||
                ((state_ff.st == stop_seq_pkg::ST_RESTART) && state_ff.partial_powerdown_flag) ||
                (state_ff.partial_powerdown_flag && !ack);
    if ((state_ff.st == stop_seq_pkg::ST_RUN) && i_stop_exec &&
        state_ff.ctrl[stop_seq_pkg::B_STOP_EN] && !i_debug_mode_enable &&
        state_ff.ctrl[stop_seq_pkg::B_PDC] && !state_ff.ctrl[stop_seq_pkg::B_PARTIAL_POWERDOWN_CONTROL]) begin
      nxt_state.pin_oe = '0;
    end else if (state_ff.st == stop_seq_pkg::ST_STOP1) begin
      nxt_state.pin_oe = '0;
    end else if (!hold_pins) begin
      nxt_state.pin_o  = live_o;
      nxt_state.pin_oe = live_oe;
    end
    if (deep || (nxt_state.st == stop_seq_pkg::ST_STOP2) ||
        (nxt_state.st == stop_seq_pkg::ST_STOP1)) begin
      nxt_state.pin_oe[stop_seq_pkg::WAKE_PIN] = 1'b0;
    end
    // pull-ups follow software only; deep stop never forces one
    nxt_state.pull = i_port_pullup_enables;

    // ****************************************************************
    // apb read path, captured in setup so the access phase has no wait
    // ****************************************************************
    rd = 32'h0000_0000;
    nxt_state.slverr = 1'b0;
    if (setup) begin
      if (i_apb.paddr == stop_seq_pkg::OFS_CTRL_ONE) begin
        rd[stop_seq_pkg::CTRL_W-1:0] = state_ff.ctrl;
      end else if (i_apb.paddr == stop_seq_pkg::OFS_CTRL_TWO) begin
        rd[stop_seq_pkg::B_PARTIAL_POWERDOWN_FLAG] = state_ff.partial_powerdown_flag;
        rd[stop_seq_pkg::B_PDF]  = state_ff.full_powerdown_flag;
        rd[stop_seq_pkg::B_STATE_LO +: 3] = state_ff.st;
      end else begin
        nxt_state.slverr = 1'b1;
      end
      nxt_state.rdata = rd;
    end else if (!i_apb.psel) begin
      nxt_state.rdata = 32'h0000_0000;
    end else begin
      nxt_state.slverr = state_ff.slverr;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_ff <= STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic run;
  logic s3;
  logic s2;

  assign run = state_ff.st == stop_seq_pkg::ST_RUN;
  assign s3  = state_ff.st == stop_seq_pkg::ST_STOP3;
  assign s2  = state_ff.st == stop_seq_pkg::ST_STOP2;

  assign o_apb.pready  = 1'b1;
  assign o_apb.pslverr = i_apb.psel && i_apb.penable && state_ff.slverr;
  assign o_apb.prdata  = state_ff.rdata;

  assign o_pin_o            = state_ff.pin_o;
  assign o_pin_oe           = state_ff.pin_oe;
  assign o_pin_pullup       = state_ff.pull;
  assign o_illegal_op_reset = state_ff.ill;
  assign o_sys_reset        = state_ff.st == stop_seq_pkg::ST_RESTART;
  assign o_lvr_enable       = o_sys_reset || state_ff.ctrl[stop_seq_pkg::B_VM_EN];
  assign o_lvr_low_trip     = o_sys_reset;
  assign o_enter_background = state_ff.bgnd;
  assign o_mem_status_err   = state_ff.mserr;
  assign o_debug_cmds_all   = run;

  // stop3 keeps state, deep modes cut power; the restart phase counts as on, except for the converter
  assign o_pwr.cpu         = !(state_ff.st == stop_seq_pkg::ST_STOP1) && !s2;
  assign o_pwr.ram         = state_ff.st != stop_seq_pkg::ST_STOP1;
  assign o_pwr.flash       = o_pwr.cpu;
  assign o_pwr.port_regs   = o_pwr.cpu;
  assign o_pwr.periph_clk  = run || o_sys_reset;
  assign o_pwr.debug_clk   = run || o_sys_reset || (s3 && state_ff.dbg_entry);
  assign o_pwr.reg_full    = !s2 && (state_ff.st != stop_seq_pkg::ST_STOP1) &&
                             (!s3 || state_ff.dbg_entry || state_ff.vm_keep);
  assign o_pwr.reg_standby = s2 || (s3 && !o_pwr.reg_full);
  assign o_pwr.adc_run     = run || (s3 && state_ff.ctrl[stop_seq_pkg::B_ADC_ASYNC] &&
                             state_ff.ctrl[stop_seq_pkg::B_VM_EN]);
  assign o_pwr.ics_run     = run || o_sys_reset ||
                             (s3 && state_ff.ctrl[stop_seq_pkg::B_REF_CLK] &&
                             state_ff.ctrl[stop_seq_pkg::B_REF_STOP]);

endmodule

/* File: testbench/stop_host_model.sv */
// stand-in for the cpu core, the serial debug host and the wake pin
// assumes one clock; every strobe changes just after a rising edge
module stop_host_model (
  input  wire logic i_mclk,
  output logic      o_stop_exec,
  output logic      o_bkgd_cmd,
  output logic      o_mem_status_cmd,
  output logic      o_irq_wake,
  output logic      o_rti_wake,
  output logic      o_wake_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // strobes and wake pin
  // ****************************************************************
  initial begin
    {o_stop_exec, o_bkgd_cmd, o_mem_status_cmd, o_irq_wake, o_rti_wake} = 5'h00;
    o_wake_pin_n = 1'b1;
  end
  // one-cycle strobe: 0 stop, 1 background, 2 status read, 3 wake timer, 4 interrupt
  task automatic strobe(input int unsigned k);
    @(posedge i_mclk);
    o_stop_exec      <= (k == 0);
    o_bkgd_cmd       <= (k == 1);
    o_mem_status_cmd <= (k == 2);
    o_rti_wake       <= (k == 3);
    o_irq_wake       <= (k == 4);
    @(posedge i_mclk);
    {o_stop_exec, o_bkgd_cmd, o_mem_status_cmd, o_irq_wake, o_rti_wake} <= 5'h00;
  endtask
  // pin pulled low for n cycles; the board pull-up lifts it once released
  task automatic press_wake(input int unsigned n);
    @(posedge i_mclk);
    o_wake_pin_n <= 1'b0;
    repeat (n) @(posedge i_mclk);
    o_wake_pin_n <= 1'b1;
  endtask
endmodule

/* File: testbench/stop_seq_asserts.sv */
// port-level assertions for the stop-mode power sequencer
// assumes it is bound onto every sequencer instance, one clock domain
module stop_seq_asserts #(
  parameter int unsigned PINS = stop_seq_pkg::PIN_COUNT
) (
  input wire logic                   i_mclk,
  input wire logic                   i_srst,
  input wire logic                   i_stop_exec,
  input wire logic                   i_bkgd_cmd,
  input wire logic                   i_mem_status_cmd,
  input wire logic [PINS-1:0]        i_port_pullup_enables,
  input wire logic [PINS-1:0]        o_pin_o,
  input wire logic [PINS-1:0]        o_pin_oe,
  input wire logic [PINS-1:0]        o_pin_pullup,
  input wire logic                   o_illegal_op_reset,
  input wire logic                   o_sys_reset,
  input wire logic                   o_lvr_enable,
  input wire logic                   o_lvr_low_trip,
  input wire logic                   o_enter_background,
  input wire logic                   o_mem_status_err,
  input wire logic                   o_debug_cmds_all,
  input wire stop_seq_pkg::pwr_ctl_t o_pwr
);
  // ****************************************************************
  // helpers and properties
  // ****************************************************************
  localparam int unsigned RC = stop_seq_pkg::RESTART_CYCLES;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // any state that is neither run nor restart is a stop mode
  wire         stopped = !o_debug_cmds_all && !o_sys_reset;
  int unsigned rcnt_ff;
  always_ff @(posedge i_mclk) begin
    if (i_srst || !o_sys_reset) rcnt_ff <= 0;
    else rcnt_ff <= rcnt_ff + 1;
  end

  AST_STOP_GATE: assert property (i_stop_exec && o_debug_cmds_all && !o_sys_reset
    |=> o_illegal_op_reset == o_debug_cmds_all) else $error("stop entry and trap disagree");
  AST_PERIPH_CLK: assert property (stopped |-> !o_pwr.periph_clk)
    else $error("peripheral clock running in stop");
  AST_DEBUG_REG: assert property (stopped && o_pwr.debug_clk
    |-> o_pwr.reg_full && !o_pwr.reg_standby) else $error("regulator dropped with debug on");
  AST_STOP1_HIZ: assert property (stopped && !o_pwr.ram |-> o_pin_oe == '0)
    else $error("pin driven in full power-down");
  AST_STOP2_HOLD: assert property (stopped && $past(stopped) && o_pwr.ram && !o_pwr.cpu
    |-> $stable(o_pin_o) && $stable(o_pin_oe)) else $error("latched pins moved");
  AST_RESTART_LEN: assert property ($fell(o_sys_reset) |-> rcnt_ff >= RC)
    else $error("restart too short");
  AST_LVR_LOW: assert property (o_sys_reset |-> o_lvr_enable && o_lvr_low_trip)
    else $error("low-voltage reset off in restart");
  AST_MEM_ERR: assert property (i_mem_status_cmd && stopped |=> o_mem_status_err)
    else $error("no error for status command in stop");
  AST_BKGD_WAKE: assert property (o_enter_background
    |-> o_debug_cmds_all && $past(i_bkgd_cmd) && $past(stopped)) else $error("bad wake");
  AST_PULLUP_FREE: assert property (stopped
    && !$past(i_port_pullup_enables[stop_seq_pkg::WAKE_PIN])
    |-> !o_pin_pullup[stop_seq_pkg::WAKE_PIN]) else $error("wake pin pull-up forced");

  cover property ($fell(o_sys_reset));
  cover property (o_enter_background);
  cover property (stopped && !o_pwr.ram);
endmodule

bind stop_mode_power_sequencer stop_seq_asserts #(.PINS(PINS)) u_chk (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_stop_exec(i_stop_exec), .i_bkgd_cmd(i_bkgd_cmd),
  .i_mem_status_cmd(i_mem_status_cmd), .i_port_pullup_enables(i_port_pullup_enables),
  .o_pin_o(o_pin_o), .o_pin_oe(o_pin_oe), .o_pin_pullup(o_pin_pullup),
  .o_illegal_op_reset(o_illegal_op_reset), .o_sys_reset(o_sys_reset),
  .o_lvr_enable(o_lvr_enable), .o_lvr_low_trip(o_lvr_low_trip),
  .o_enter_background(o_enter_background), .o_mem_status_err(o_mem_status_err),
  .o_debug_cmds_all(o_debug_cmds_all), .o_pwr(o_pwr));

/* File: testbench/tb.sv */
// self-checking bench for the stop-mode power sequencer
// assumes the host model and the bound checker compile ahead of it
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic                   i_mclk = 1'b0;
  logic                   i_srst;
  stop_seq_pkg::apb_req_t apb_req;
  stop_seq_pkg::apb_rsp_t apb_rsp;
  stop_seq_pkg::pwr_ctl_t pwr;
  logic                   dbg_en, vdd_low;
  logic [5:0]             port_data, port_dir, pullups;
  logic [5:0]             per_en, per_out, per_oe, pin_o, pin_oe, pin_pu;
  logic                   stop_exec, bkgd_cmd, mem_cmd, irq_wake, rti_wake, wake_n;
  logic                   ill_rst, sys_rst, lvr_en, lvr_lo, enter_bg, mem_err, dbg_all, err;
  logic [31:0]            rd;
  int                     fail_count = 0;
  int                     samples_checked = 0;

  always #12.5 i_mclk = ~i_mclk;

  stop_host_model u_host (.i_mclk(i_mclk), .o_stop_exec(stop_exec), .o_bkgd_cmd(bkgd_cmd),
    .o_mem_status_cmd(mem_cmd), .o_irq_wake(irq_wake), .o_rti_wake(rti_wake),
    .o_wake_pin_n(wake_n));
  stop_mode_power_sequencer u_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_apb(apb_req),
    .o_apb(apb_rsp), .i_stop_exec(stop_exec), .i_debug_mode_enable(dbg_en),
    .i_bkgd_cmd(bkgd_cmd), .i_mem_status_cmd(mem_cmd), .i_irq_wake(irq_wake),
    .i_rti_wake(rti_wake), .i_wake_pin_n(wake_n), .i_vdd_below_low_trip(vdd_low),
    .i_port_data(port_data), .i_port_dir(port_dir), .i_port_pullup_enables(pullups),
    .i_periph_en(per_en), .i_periph_out(per_out), .i_periph_oe(per_oe), .o_pin_o(pin_o),
    .o_pin_oe(pin_oe), .o_pin_pullup(pin_pu), .o_illegal_op_reset(ill_rst),
    .o_sys_reset(sys_rst), .o_lvr_enable(lvr_en), .o_lvr_low_trip(lvr_lo),
    .o_enter_background(enter_bg), .o_mem_status_err(mem_err),
    .o_debug_cmds_all(dbg_all), .o_pwr(pwr));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge i_mclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: adr, pwdata: wd};
    @(posedge i_mclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge i_mclk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  // bounded wait for the restart level; n counts the edges it took
  task automatic wait_sys(input logic lvl, output int unsigned n);
    n = 0;
    while (sys_rst !== lvl && n < 200) begin
      @(posedge i_mclk);
      n++;
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    apb(0, stop_seq_pkg::OFS_CTRL_ONE, 0);
    chk("ctrl reset", 32'h008, rd);
    apb(1, stop_seq_pkg::OFS_CTRL_ONE, 32'h1ff);
    apb(1, 8'h08, 32'h0);
    chk("unmapped", 33'h1_0000_0000, {err, rd});
    apb(0, stop_seq_pkg::OFS_CTRL_ONE, 0);
    chk("ctrl rw", 32'h1ff, rd);
  endtask
  task automatic t_illegal;
    apb(1, stop_seq_pkg::OFS_CTRL_ONE, 32'h000);
    u_host.strobe(0);
    #1 chk("illegal trap", 2'b11, {ill_rst, dbg_all});
    @(posedge i_mclk);
    #1 chk("trap pulse", 0, ill_rst);
  endtask
  task automatic t_stop3;
    logic [8:0] ctl [4] = '{9'h005, 9'h019, 9'h0e9, 9'h0a1};
    logic [2:0] exp [4] = '{3'b000, 3'b100, 3'b011, 3'b000};
    // 0x0e9 keeps the monitor on so the converter may run
    for (int i = 0; i < 4; i++) begin
      apb(1, stop_seq_pkg::OFS_CTRL_ONE, {23'h0, ctl[i]});
      u_host.strobe(0);
      #1 chk("stop3 entry", 0, dbg_all);
      chk("stop3 units", exp[i], {pwr.reg_full, pwr.adc_run, pwr.ics_run});
      chk("stop3 periph clk", 0, pwr.periph_clk);
      u_host.strobe(4);
      #1 chk("stop3 wake", 2'b10, {dbg_all, sys_rst});
    end
  endtask
  task automatic t_debug;
    @(posedge i_mclk);
    dbg_en <= 1'b1;
    apb(1, stop_seq_pkg::OFS_CTRL_ONE, 32'h007);
    u_host.strobe(0);
    #1 chk("debug stop", 4'b1100, {pwr.debug_clk, pwr.reg_full, pwr.reg_standby, pwr.periph_clk});
    u_host.strobe(2);
    #1 chk("status cmd err", 1, mem_err);
    u_host.strobe(1);
    #1 chk("background wake", 2'b11, {enter_bg, dbg_all});
    @(posedge i_mclk);
    dbg_en <= 1'b0;
  endtask
  task automatic t_stop2;
    int unsigned m;
    @(posedge i_mclk);
    port_dir <= 6'h3f;
    port_data <= 6'h15;
    pullups <= 6'h00; // pull-up left off by software
    apb(1, stop_seq_pkg::OFS_CTRL_ONE, 32'h007);
    u_host.strobe(0);
    #1 chk("stop2 pins", 11'h3f5, {pin_oe, pin_o[4:0]});
    chk("stop2 power", 5'b01000, {pwr.cpu, pwr.ram, pwr.flash, pwr.port_regs, pwr.periph_clk});
    chk("stop2 pull-up", 0, pin_pu[5]);
    @(posedge i_mclk);
    port_data <= 6'h2a;
    u_host.press_wake(3);
    chk("pins held", 5'h15, pin_o[4:0]);
    wait_sys(1, m);
    chk("pin wake", 1, sys_rst);
    vdd_low <= 1'b1;
    repeat (60) @(posedge i_mclk);
    chk("low supply hold", 3'b111, {sys_rst, lvr_en, lvr_lo});
    vdd_low <= 1'b0;
    wait_sys(0, m);
    chk("supply release", 1, m < 6);
    apb(0, stop_seq_pkg::OFS_CTRL_ONE, 0);
    chk("ctrl after wake", 32'h008, rd);
    apb(0, stop_seq_pkg::OFS_CTRL_TWO, 0);
    chk("partial flag", 2'b01, rd[1:0]);
    chk("pins still held", 5'h15, pin_o[4:0]);
    per_en <= 6'h01;
    per_out <= 6'h05;
    per_oe <= 6'h3e;
    apb(1, stop_seq_pkg::OFS_CTRL_TWO, 32'h100);
    repeat (2) @(posedge i_mclk);
    #1 chk("pins released", 10'h3cb, {pin_oe[4:0], pin_o[4:0]});
    apb(0, stop_seq_pkg::OFS_CTRL_TWO, 0);
    chk("flag acked", 0, rd[1:0]);
    per_en <= 6'h00;
  endtask
  task automatic t_stop1;
    int unsigned m;
    @(posedge i_mclk);
    pullups <= 6'h20; // software enables the wake pin pull-up itself
    port_data <= 6'h3f;
    apb(1, stop_seq_pkg::OFS_CTRL_ONE, 32'h103);
    u_host.strobe(0);
    #1 chk("stop1 hi-z", 6'h00, pin_oe);
    u_host.strobe(3);
    wait_sys(1, m);
    chk("timer wake", 1, sys_rst);
    wait_sys(0, m);
    chk("restart length", stop_seq_pkg::RESTART_CYCLES, m);
    apb(0, stop_seq_pkg::OFS_CTRL_TWO, 0);
    chk("full flag", 2'b10, rd[1:0]);
    apb(1, stop_seq_pkg::OFS_CTRL_TWO, 32'h100);
    apb(0, stop_seq_pkg::OFS_CTRL_TWO, 0);
    chk("full flag acked", 0, rd[1:0]);
  endtask

  // ****************************************************************
  // sequence, watchdog and verdict
  // ****************************************************************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    i_srst <= 1'b1;
    apb_req <= '0;
    {dbg_en, vdd_low} <= 2'b00;
    {port_data, port_dir, pullups, per_en, per_out, per_oe} <= 36'h0;
    repeat (8) @(posedge i_mclk);
    i_srst <= 1'b0;
    t_regs;
    t_illegal;
    t_stop3;
    t_debug;
    t_stop2;
    t_stop1;
    end_sim;
  end
  // the whole sequence needs well under 1000 cycles; allow twenty times that
  initial begin
    #500000;
    fail_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    end_sim;
  end
endmodule
